/* design/sdrci_pkg.sv */
// Shared constants and types for the SDRAM command interface.
// Behaviour
// [RULE1] All inputs captured on rising clock edge
// [RULE2] Four banks, 4096 rows, width-dependent columns
// [RULE3] Controller activates a row before read/write
// [RULE4] Activate takes bank address and row
// [RULE5] Read/write address gives burst start column
// [RULE6] Burst length 1,2,4,8 or page; terminable
// [RULE7] Internal counter steps burst column addresses
// [RULE8] Auto precharge closes row after burst
// [RULE9] New column address accepted every cycle
// [RULE10] Precharge one bank while another is accessed
// [RULE11] Clock gate low: suspend or power-down states
// [RULE12] Clock gate asynchronous in power-down, self refresh
// [RULE13] Controller may tie clock gate high
// [RULE14] Commands ignored while chip select high
// [RULE15] Running burst and masking continue, select high
// [RULE16] Command decoded from four strobes together
// [RULE17] Read data leaves through clocked output registers
// [RULE18] Extended-temp: 16ms refresh, no self refresh
// [RULE19] Mask blocks writes; reads float two clocks later
// [RULE20] Column width per variant; line 10 auto precharge
// [RULE21] Precharge line high closes all banks
// [RULE22] Controller drives opcode on mode load
// [RULE23] Controller drives no-op when idle
package sdrci_pkg;
  // ------------------------------------------------------------
  // command codes {select, row, column, write}, all active low
  // ------------------------------------------------------------
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;
  // ------------------------------------------------------------
  // address fields and mode register layout
  // ------------------------------------------------------------
  localparam int PRECHARGE_SELECT_LINE = 10;
  localparam int BURST_LENGTH_LSB = 0;
  localparam int BURST_LENGTH_W = 3;
  localparam logic [2:0] BURST_LENGTH_PAGE = 3'h7;
  localparam logic [11:0] MODE_RESET = 12'h000;
  localparam int BANK_COUNT = 4;
  // ------------------------------------------------------------
  // power states
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    PS_RUN = 5'h01,
    PS_PRE_PD = 5'h02,
    PS_ACT_PD = 5'h04,
    PS_SUSPEND = 5'h08,
    PS_SELF_REF = 5'h10
  } sdrci_power_e;
endpackage

/* design/sdrci_mem.sv */
// Storage array with byte-lane writes and registered read data.
`timescale 1ns/10ps
module sdrci_mem #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [1:0] laneEn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wrData,
  output logic [DATA_W-1:0] rdData
);
  localparam int LANE_W = DATA_W / 2;

  // one array per lane so that each array has a single writing process
  genvar lane;
  for (lane = 0; lane < 2; lane++) begin : g_lane
    logic [LANE_W-1:0] cells [2**ADDR_W];

    always_ff @(posedge clk) begin
      if (wrEn && laneEn[lane]) begin
        cells[addr] <= wrData[lane*LANE_W +: LANE_W];
      end
      rdData[lane*LANE_W +: LANE_W] <= cells[addr];
    end
  end
endmodule

/* design/sdrci_core.sv */
// Command decoder, bank state, burst engine and power states of the SDRAM.
`timescale 1ns/10ps
module sdrci_core
  import sdrci_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int ROW_W = 12,
  parameter int COL_W = 8,
  parameter bit EXT_TEMP = 1'b0
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clockGate,
  input wire logic chipSel_n,
  input wire logic rowStrobe_n,
  input wire logic colStrobe_n,
  input wire logic writeStrobe_n,
  input wire logic [1:0] bankAddr,
  input wire logic [11:0] addr,
  input wire logic data_mask_low,
  input wire logic data_mask_high,
  input wire logic [DATA_W-1:0] dqIn,
  output logic [DATA_W-1:0] dqOut,
  output logic [1:0] dqOe,
  output logic [sdrci_pkg::BANK_COUNT-1:0] bankOpen,
  output logic burstActive,
  output sdrci_pkg::sdrci_power_e powerState
);
  import sdrci_pkg::*;

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  logic [3:0] cmd;
  logic cmdValid;
  logic actCmd;
  logic rdCmd;
  logic wrCmd;
  logic preCmd;
  logic bstCmd;
  logic lmrCmd;
  logic refCmd;

  assign cmd = {chipSel_n, rowStrobe_n, colStrobe_n, writeStrobe_n}; // [RULE16] [RULE1]
  // select low, running clock and normal state are all needed to act
  assign cmdValid = !chipSel_n && clockGate && powerState == PS_RUN; // [RULE14]
  assign actCmd = cmdValid && cmd == CMD_ACT;
  assign rdCmd = cmdValid && cmd == CMD_RD;
  assign wrCmd = cmdValid && cmd == CMD_WR;
  assign preCmd = cmdValid && cmd == CMD_PRE;
  assign bstCmd = cmdValid && cmd == CMD_BST;
  assign lmrCmd = cmdValid && cmd == CMD_LMR;
  assign refCmd = !chipSel_n && cmd == CMD_REF && powerState == PS_RUN;

  // ------------------------------------------------------------
  // mode register
  // ------------------------------------------------------------
  logic [11:0] modeReg;
  logic [2:0] blCode;
  logic [COL_W-1:0] lenMask;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      modeReg <= MODE_RESET;
    end else if (lmrCmd) begin
      modeReg <= addr;
    end
  end

  assign blCode = modeReg[BURST_LENGTH_LSB +: BURST_LENGTH_W];

  always_comb begin
    lenMask = '0; // reserved codes behave as a single beat
    if (blCode == BURST_LENGTH_PAGE) begin
      lenMask = '1; // [RULE6]
    end else if (blCode < 3'h4) begin
      lenMask = COL_W'((1 << blCode) - 1); // [RULE6]
    end
  end

  // ------------------------------------------------------------
  // burst engine
  // ------------------------------------------------------------
  logic startNow;
  logic burstWrite;
  logic burstAutoPre;
  logic [1:0] burstBank;
  logic [COL_W-1:0] burstStart;
  logic [COL_W-1:0] burstIdx;
  logic [1:0] curBank;
  logic [COL_W-1:0] curStart;
  logic [COL_W-1:0] curIdx;
  logic [COL_W-1:0] curCol;
  logic curWrite;
  logic curAutoPre;
  logic suspend;
  logic beat;
  logic lastBeat;
  logic [ROW_W-1:0] rowOf [BANK_COUNT];

  assign startNow = rdCmd || wrCmd;
  assign suspend = !clockGate; // a stalled clock freezes the burst counter
  assign curBank = startNow ? bankAddr : burstBank; // [RULE5]
  assign curStart = startNow ? addr[COL_W-1:0] : burstStart; // [RULE20]
  assign curIdx = startNow ? '0 : burstIdx;
  assign curWrite = startNow ? wrCmd : burstWrite;
  assign curAutoPre = startNow ? addr[PRECHARGE_SELECT_LINE] : burstAutoPre; // [RULE20]
  // wrap inside the aligned block of the burst length
  assign curCol = (curStart & ~lenMask) | ((curStart + curIdx) & lenMask); // [RULE7]
  // a terminate cancels the beat of its own cycle
  assign beat = startNow || (burstActive && !suspend && !bstCmd); // [RULE6]
  assign lastBeat = curIdx == lenMask;

  // a new read or write replaces any running burst at once
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      burstActive <= 1'b0;
      burstWrite <= 1'b0;
      burstAutoPre <= 1'b0;
      burstBank <= '0;
      burstStart <= '0;
      burstIdx <= '0;
    end else if (startNow) begin
      burstActive <= !lastBeat; // [RULE9]
      burstWrite <= wrCmd;
      burstAutoPre <= addr[PRECHARGE_SELECT_LINE];
      burstBank <= bankAddr;
      burstStart <= addr[COL_W-1:0];
      burstIdx <= COL_W'(1);
    end else if (bstCmd) begin
      burstActive <= 1'b0; // [RULE6]
    end else if (beat) begin
      // keeps running whatever chip select does
      burstActive <= !lastBeat; // [RULE15]
      burstIdx <= burstIdx + COL_W'(1); // [RULE7]
    end
  end

  // ------------------------------------------------------------
  // bank state
  // ------------------------------------------------------------
  logic autoClose;

  assign autoClose = beat && lastBeat && curAutoPre; // [RULE8]

  genvar b;
  for (b = 0; b < BANK_COUNT; b++) begin : g_bank
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        bankOpen[b] <= 1'b0;
        rowOf[b] <= '0;
      end else if (actCmd && bankAddr == 2'(b)) begin
        bankOpen[b] <= 1'b1; // [RULE4]
        rowOf[b] <= addr[ROW_W-1:0]; // [RULE4]
      end else if (preCmd && (addr[PRECHARGE_SELECT_LINE] || bankAddr == 2'(b))) begin
        bankOpen[b] <= 1'b0; // [RULE21] [RULE10]
      end else if (autoClose && curBank == 2'(b)) begin
        bankOpen[b] <= 1'b0; // [RULE8]
      end
    end
  end

  // ------------------------------------------------------------
  // array access and data path
  // ------------------------------------------------------------
  localparam int ADDR_W = 2 + ROW_W + COL_W;
  localparam int LANE_W = DATA_W / 2;
  logic [DATA_W-1:0] rdData;
  logic rdValid;
  logic [1:0] maskDly;

  sdrci_mem #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_mem (
    .clk(core_clk),
    .wrEn(beat && curWrite),
    .laneEn(~{data_mask_high, data_mask_low}), // [RULE19]
    .addr({curBank, rowOf[curBank], curCol}), // [RULE2]
    .wrData(dqIn),
    .rdData(rdData)
  );

  // mask at edge n governs the output driven at edge n+2
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdValid <= 1'b0;
      maskDly <= 2'h0;
      dqOut <= '0;
      dqOe <= 2'h0;
    end else begin
      rdValid <= beat && !curWrite;
      maskDly <= {data_mask_high, data_mask_low}; // [RULE15]
      dqOut <= rdData; // [RULE17]
      dqOe <= {2{rdValid}} & ~maskDly; // [RULE19]
    end
  end

  // ------------------------------------------------------------
  // power states
  // ------------------------------------------------------------
  logic gateMeta;
  logic gateSync;
  logic gateLowSeen;

  // input buffers are off here, so the gate is treated as asynchronous
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      gateMeta <= 1'b0;
      gateSync <= 1'b0;
    end else begin
      gateMeta <= clockGate; // [RULE12]
      gateSync <= gateMeta;
    end
  end

  // the synchroniser still holds a stale high just after entry; wait for its low first
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      gateLowSeen <= 1'b0;
    end else if (powerState == PS_RUN || powerState == PS_SUSPEND) begin
      gateLowSeen <= 1'b0;
    end else if (!gateSync) begin
      gateLowSeen <= 1'b1; // [RULE12]
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      powerState <= PS_RUN;
    end else begin
      case (powerState)
        PS_RUN: begin
          if (!clockGate) begin
            if (burstActive) begin
              powerState <= PS_SUSPEND; // [RULE11]
            end else if (|bankOpen) begin
              powerState <= PS_ACT_PD; // [RULE11]
            end else if (refCmd && !EXT_TEMP) begin
              powerState <= PS_SELF_REF; // [RULE11] [RULE18]
            end else begin
              powerState <= PS_PRE_PD; // [RULE11]
            end
          end
        end
        PS_SUSPEND: begin
          if (clockGate) begin
            powerState <= PS_RUN;
          end
        end
        PS_PRE_PD, PS_ACT_PD, PS_SELF_REF: begin
          if (gateSync && gateLowSeen) begin
            powerState <= PS_RUN; // [RULE12]
          end
        end
        default: begin
          powerState <= PS_RUN;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  selectMask_a: assert property (chipSel_n && !autoClose |=> $stable(bankOpen)) // [RULE14]
    else $error("bank state changed while deselected");
  actOpen_a: assert property (actCmd |=> bankOpen[$past(bankAddr)]) // [RULE4]
    else $error("activate did not open bank");
  readOut_a: assert property (beat && !curWrite && !data_mask_low |-> ##2 dqOe[0]) // [RULE17]
    else $error("read data not driven two cycles later");
  readMask_a: assert property (data_mask_high |-> ##2 !dqOe[1]) // [RULE19]
    else $error("masked lane was driven");
  prechargeAll_a: assert property (preCmd && addr[PRECHARGE_SELECT_LINE] // [RULE21]
    |=> bankOpen == '0)
    else $error("precharge all left a bank open");
  burstKeep_a: assert property (burstActive && chipSel_n && clockGate && !lastBeat
    |=> burstActive && burstIdx == $past(burstIdx) + COL_W'(1)) // [RULE15]
    else $error("burst stopped while deselected");
  autoPre_a: assert property (autoClose && !actCmd |=> !bankOpen[$past(curBank)]) // [RULE8]
    else $error("auto precharge left row open");
  suspendEnter_a: assert property (powerState == PS_RUN && burstActive && !clockGate
    |=> powerState == PS_SUSPEND) // [RULE11]
    else $error("clock suspend not entered");
  wakeSync_a: assert property ((powerState == PS_PRE_PD && clockGate) [*2] |-> ##2
    powerState == PS_RUN) // [RULE12]
    else $error("power-down exit not after two flops");

  readBurst_c: cover property (rdCmd ##1 burstActive [*3]);
  writeBurst_c: cover property (wrCmd ##1 burstActive ##1 !burstActive);
  selfRef_c: cover property (powerState == PS_SELF_REF);
  suspend_c: cover property (powerState == PS_SUSPEND ##1 powerState == PS_RUN);
endmodule

/* testbench/sdrci_ctrl_model.sv */
// Controller-side partner model: command, address, mask, clock-gate and write-data pins.
`timescale 1ns/10ps
module sdrci_ctrl_model (
  input wire logic core_clk,
  output logic clockGate,
  output logic chipSel_n,
  output logic rowStrobe_n,
  output logic colStrobe_n,
  output logic writeStrobe_n,
  output logic [1:0] bankAddr,
  output logic [11:0] addr,
  output logic data_mask_low,
  output logic data_mask_high,
  output logic [15:0] dqIn
);
  initial begin
    clockGate = 1'b1;
    {chipSel_n, rowStrobe_n, colStrobe_n, writeStrobe_n} = 4'h7;
    {bankAddr, addr, data_mask_high, data_mask_low, dqIn} = '0;
  end

  // all pins change together just after an edge and hold to the next
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
                     input logic [15:0] d, input logic [1:0] m, input logic g);
    @(posedge core_clk);
    {chipSel_n, rowStrobe_n, colStrobe_n, writeStrobe_n} <= c;
    bankAddr <= b;
    addr <= a;
    dqIn <= d;
    {data_mask_high, data_mask_low} <= m;
    clockGate <= g;
  endtask
endmodule

/* testbench/tb_sdram_command_interface.sv */
// Self-checking bench for the SDRAM command interface.
`timescale 1ns/10ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_sdram_command_interface;
  import sdrci_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clockGate, chipSel_n, rowStrobe_n, colStrobe_n, writeStrobe_n;
  logic data_mask_low, data_mask_high, burstActive;
  logic [1:0] bankAddr, dqOe;
  logic [11:0] addr;
  logic [15:0] dqIn, dqOut, laneMask, wData;
  logic [3:0] bankOpen;
  sdrci_power_e powerState;
  logic [15:0] mem [0:255];
  logic [17:0] expQ [$];
  logic [17:0] note;
  logic [2:0] codes [5] = '{3'h7, 3'h0, 3'h1, 3'h2, 3'h3};
  logic [15:0] lfsrState = 16'hABC2;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;

  always #50 core_clk = ~core_clk;

  sdrci_core #(.ROW_W(4)) i_dut (.core_clk(core_clk), .reset_n(reset_n),
    .clockGate(clockGate), .chipSel_n(chipSel_n), .rowStrobe_n(rowStrobe_n),
    .colStrobe_n(colStrobe_n), .writeStrobe_n(writeStrobe_n), .bankAddr(bankAddr),
    .addr(addr), .data_mask_low(data_mask_low), .data_mask_high(data_mask_high),
    .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .bankOpen(bankOpen),
    .burstActive(burstActive), .powerState(powerState));

  sdrci_ctrl_model i_ctrl (.core_clk(core_clk), .clockGate(clockGate),
    .chipSel_n(chipSel_n), .rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n),
    .writeStrobe_n(writeStrobe_n), .bankAddr(bankAddr), .addr(addr),
    .data_mask_low(data_mask_low), .data_mask_high(data_mask_high), .dqIn(dqIn));

  function automatic logic [15:0] rnd();
    lfsrState = {lfsrState[14:0], lfsrState[15] ^ lfsrState[13] ^ lfsrState[12] ^ lfsrState[10]};
    return lfsrState;
  endfunction

  task automatic op(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
    i_ctrl.cmd(c, b, a, rnd(), 2'h0, 1'b1);
  endtask

  // read n beats of bank 0; fill is the command issued on the beats after the first
  task automatic rd(input int col, input int n, input int wrap, input logic ap, input int mb,
                    input logic [3:0] fill);
    int c;
    for (int i = 0; i < n; i++) begin
      c = (col & ~(wrap - 1)) | ((col + i) & (wrap - 1));
      expQ.push_back({(i == mb) ? 2'b10 : 2'b11, mem[c]});
      i_ctrl.cmd((i == 0) ? CMD_RD : fill, (i == 0) ? 2'h0 : 2'h2,
                 (i == 0) ? (12'(col) | {ap, 10'h000}) : 12'h000, rnd(),
                 (i == mb) ? 2'b01 : 2'b00, 1'b1);
    end
  endtask

  // gate low two edges, then high; exit takes the synchroniser's three edges
  task automatic pwr(input sdrci_power_e s, input logic [3:0] c);
    i_ctrl.cmd(c, 2'h0, 12'h000, rnd(), 2'h0, 1'b0);
    i_ctrl.cmd(4'h7, 2'h0, 12'h000, rnd(), 2'h0, 1'b0);
    @(negedge core_clk);
    `CHK(powerState, s)
    op(4'h7, 2'h0, 12'h000);
    @(negedge core_clk);
    `CHK(powerState, s)
    repeat (4) op(4'h7, 2'h0, 12'h000);
    @(negedge core_clk);
    `CHK(powerState, PS_RUN)
  endtask

  task automatic close_out();
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // read data checker: oldest note against each driven beat
  // ------------------------------------------------------------
  always @(negedge core_clk) begin
    if (reset_n && dqOe !== 2'b00) begin
      note = (expQ.size() > 0) ? expQ.pop_front() : 18'h3FFFF;
      laneMask = {{8{note[17]}}, {8{note[16]}}};
      `CHK({dqOe, dqOut & laneMask}, {note[17:16], note[15:0] & laneMask})
    end
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      close_out();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    `CHK({bankOpen, powerState}, {4'h0, PS_RUN})
    op(CMD_LMR, 2'h0, 12'h003);
    op(CMD_ACT, 2'h0, 12'h005);
    for (int i = 0; i < 8; i++) begin
      mem[i] = rnd();
      i_ctrl.cmd((i == 0) ? CMD_WR : 4'h7, 2'h0, 12'h000, mem[i], 2'h0, 1'b1);
    end
    foreach (codes[k]) begin
      op(CMD_PRE, 2'h0, 12'h400);
      op(4'h7, 2'h0, 12'h000);
      @(negedge core_clk);
      `CHK({bankOpen, burstActive}, 5'h00)
      op(CMD_LMR, 2'h0, {9'h000, codes[k]});
      op(CMD_ACT, 2'h0, 12'h005);
      if (codes[k] == 3'h7) begin
        rd(2, 3, 256, 1'b0, -1, 4'hD);
        @(negedge core_clk);
        `CHK(burstActive, 1'b1)
        op(CMD_BST, 2'h0, 12'h000);
      end else begin
        rd(5, 1 << codes[k], 1 << codes[k], 1'b0, (1 << codes[k]) - 1, 4'hD);
      end
      if (codes[k] == 3'h0) begin
        repeat (2) op(4'h7, 2'h0, 12'h000);
        wData = rnd();
        mem[3][7:0] = wData[7:0];
        i_ctrl.cmd(CMD_WR, 2'h0, 12'h003, wData, 2'b10, 1'b1);
      end
    end
    // back-to-back single reads at random columns
    for (int i = 0; i < 4; i++) rd(rnd() & 7, 1, 8, 1'b0, -1, 4'hD);
    op(CMD_BST, 2'h0, 12'h000);
    // gate low in mid-burst: the burst waits, then runs on from where it stood
    rd(0, 2, 8, 1'b0, -1, 4'hD);
    repeat (2) i_ctrl.cmd(4'h7, 2'h0, 12'h000, rnd(), 2'h0, 1'b0);
    @(negedge core_clk);
    `CHK({burstActive, powerState}, {1'b1, PS_SUSPEND})
    for (int i = 2; i < 8; i++) begin
      expQ.push_back({2'b11, mem[i]});
      op(4'h7, 2'h0, 12'h000);
    end
    op(CMD_ACT, 2'h2, 12'h009);
    rd(1, 8, 8, 1'b1, -1, CMD_PRE);
    op(4'h7, 2'h0, 12'h000);
    @(negedge core_clk);
    `CHK(bankOpen, 4'h0)
    op(CMD_ACT, 2'h0, 12'h005);
    pwr(PS_ACT_PD, 4'h7);
    op(CMD_PRE, 2'h0, 12'h400);
    pwr(PS_PRE_PD, 4'h7);
    pwr(PS_SELF_REF, CMD_REF);
    repeat (4) op(4'h7, 2'h0, 12'h000);
    `CHK(expQ.size(), 0)
    close_out();
  end
endmodule
